// [logic/psda_pkg.sv]
package psda_pkg;
   // Operation codes on the instruction control port
   typedef enum logic [2:0] {
      PSDA_OP_NONE,
      PSDA_OP_TBL_RD_LO,
      PSDA_OP_TBL_RD_HI,
      PSDA_OP_TBL_WR_LO,
      PSDA_OP_TBL_WR_HI,
      PSDA_OP_DATA_RD
   } psda_op_t;

   localparam int          PSDA_PADDR_W        = 24;
   localparam int          PSDA_PWORD_W        = 24;
   localparam int          PSDA_DATA_W         = 16;
   localparam int          PSDA_PAGE_W         = 8;
   localparam int          PSDA_VIS_EN_BIT     = 2;
   localparam int          PSDA_TBL_CFG_BIT    = 7;
   localparam int          PSDA_EA_MSB         = 15;
   localparam int          PSDA_VIS_LOW_BITS   = 15;
   localparam logic [15:0] PSDA_WINDOW_BASE    = 16'h8000;
   localparam logic [1:0]  PSDA_STALL_MOVE     = 2'h1;
   localparam logic [1:0]  PSDA_STALL_OTHER    = 2'h2;
   localparam logic [1:0]  PSDA_STALL_REPEAT   = 2'h0;
   localparam logic [7:0]  PSDA_PAGE_RESET     = 8'h00;
   localparam logic [15:0] PSDA_CORE_CTL_RESET = 16'h0000;
endpackage

// [logic/psda_extract.sv]
`timescale 1ns/10ps
// Steers the addressed part of a 24-bit program word onto the 16-bit data word
module psda_extract
   import psda_pkg::*;
(
   // Selection
   input  wire logic        highWord,
   input  wire logic        byteMode,
   input  wire logic        byteSel,
   // Data
   input  wire logic [23:0] progWord,
   output logic      [15:0] dataWord
);
   always_comb begin
      if (!highWord) begin
         if (!byteMode)
            dataWord = progWord[15:0];
         else if (byteSel)
            dataWord = {8'h00, progWord[15:8]};
         else
            dataWord = {8'h00, progWord[7:0]};
      end else begin
         if (!byteMode)
            dataWord = {8'h00, progWord[23:16]};
         else if (byteSel)
            dataWord = 16'h0000;
         else
            dataWord = {8'h00, progWord[23:16]};
      end
   end
endmodule

// [logic/psda_bridge.sv]
`timescale 1ns/10ps
// Overview of operation
// - Word-mode low table read returns program bits 15..0; low write targets them.
// - Byte-mode low read puts upper byte if byte select, else lower byte.
// - Word-mode high read returns bits 23..16, upper data byte zero.
// - Byte-mode high read with byte select one returns zero.
// - Only high table read/write reach the upper eight program bits.
// - Program addresses step by two per word; low/high spaces share ranges.
// - Table page MSB selects user (0) or configuration (1) memory.
// - Redirect data access when EA MSB set and control bit 2 set.
// - Visibility page gives upper address bits, EA low 15 bits the rest.
// - Window covers data addresses 8000h upward.
// - Window reads return only the low 16 program bits.
// - Window redirection is suspended during table reads and writes.
// - A window data read makes one program fetch; extra cycles as below.
// - Outside repeat: move one extra cycle, others two extra cycles.
// - In repeat: first, last, interrupt exit, re-entry two extra; else none.
// - Table address is table page concatenated above the 16-bit EA.
// - Window address ignores EA bit 15; bit 15 is page bit 0.
module psda_bridge
   import psda_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Register writes from the core
   input  wire logic        tablePageWr,
   input  wire logic        visPageWr,
   input  wire logic        coreCtlWr,
   input  wire logic [15:0] regWrData,
   // Instruction control
   input  wire logic        opValid,
   input  wire psda_op_t    opCode,
   input  wire logic [15:0] effAddr,
   input  wire logic        byteMode,
   input  wire logic [15:0] wrData,
   input  wire logic        moveInstr,
   input  wire logic        inRepeat,
   input  wire logic        repFirst,
   input  wire logic        repLast,
   input  wire logic        repIrqExit,
   input  wire logic        repIrqReentry,
   // Program memory port
   input  wire logic [23:0] progRdData,
   output logic             progRdEn,
   output logic             progWrEn,
   output logic [23:0]      progAddr,
   output logic [23:0]      progWrData,
   output logic [2:0]       progWrLanes,
   output logic             progConfigSpace,
   // Data path answer
   output logic             dataValid,
   output logic [15:0]      dataOut,
   output logic             windowHit,
   output logic             cpuStall,
   // Register state
   output logic [7:0]       tablePageReg,
   output logic [7:0]       visibilityPageReg,
   output logic [15:0]      coreControlReg
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  tablePage_q;
   logic [7:0]  visPage_q;
   logic [15:0] coreCtl_q;

   always_ff @(posedge clk) begin
      if (rst)
         tablePage_q <= PSDA_PAGE_RESET;
      else if (tablePageWr)
         tablePage_q <= regWrData[7:0];
   end

   always_ff @(posedge clk) begin
      if (rst)
         visPage_q <= PSDA_PAGE_RESET;
      else if (visPageWr)
         visPage_q <= regWrData[7:0];
   end

   always_ff @(posedge clk) begin
      if (rst)
         coreCtl_q <= PSDA_CORE_CTL_RESET;
      else if (coreCtlWr)
         coreCtl_q <= regWrData;
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic isTable(input psda_op_t op);
      isTable = (op == PSDA_OP_TBL_RD_LO) || (op == PSDA_OP_TBL_RD_HI) ||
                (op == PSDA_OP_TBL_WR_LO) || (op == PSDA_OP_TBL_WR_HI);
   endfunction

   function automatic logic isHigh(input psda_op_t op);
      isHigh = (op == PSDA_OP_TBL_RD_HI) || (op == PSDA_OP_TBL_WR_HI);
   endfunction

   logic        tableOp;
   logic        tableBusy_q;
   logic        hit;
   logic [23:0] tblAddr;
   logic [23:0] visAddr;
   logic        byteSel;
   logic [1:0]  extra;

   assign tableOp = opValid && isTable(opCode);
   assign byteSel = effAddr[0];

   // Table page over the full EA; the same EA reaches low and high halves
   assign tblAddr = {tablePage_q, effAddr};

   // EA bit 15 is always one here and is replaced by page bit 0
   assign visAddr = {1'b0, visPage_q,
                     effAddr[PSDA_VIS_LOW_BITS-1:0]};

   // A table access in flight blocks the window, including the cycle after
   assign hit = opValid && (opCode == PSDA_OP_DATA_RD) &&
                (effAddr >= PSDA_WINDOW_BASE) &&
                effAddr[PSDA_EA_MSB] && coreCtl_q[PSDA_VIS_EN_BIT] &&
                !tableBusy_q && !tableOp;

   always_ff @(posedge clk) begin
      if (rst)
         tableBusy_q <= 1'b0;
      else
         tableBusy_q <= tableOp;
   end

   // ------------------------------------------------------------
   // Extra cycles for window reads
   // ------------------------------------------------------------
   always_comb begin
      if (!inRepeat)
         extra = moveInstr ? PSDA_STALL_MOVE : PSDA_STALL_OTHER;
      else if (repFirst || repLast || repIrqExit || repIrqReentry)
         extra = PSDA_STALL_OTHER;
      else
         extra = PSDA_STALL_REPEAT;
   end

   logic [1:0] stallCnt_q;
   logic       busy;
   assign busy = (stallCnt_q != 2'h0);

   always_ff @(posedge clk) begin
      if (rst)
         stallCnt_q <= 2'h0;
      else if (busy)
         stallCnt_q <= stallCnt_q - 2'h1;
      else if (hit)
         stallCnt_q <= extra;
   end

   // ------------------------------------------------------------
   // Program memory port
   // ------------------------------------------------------------
   logic wrOp;
   assign wrOp = opValid && ((opCode == PSDA_OP_TBL_WR_LO) || (opCode == PSDA_OP_TBL_WR_HI));

   always_ff @(posedge clk) begin
      if (rst) begin
         progRdEn        <= 1'b0;
         progWrEn        <= 1'b0;
         progAddr        <= 24'h000000;
         progWrData      <= 24'h000000;
         progWrLanes     <= 3'h0;
         progConfigSpace <= 1'b0;
      end else begin
         progRdEn <= !busy && (hit || (tableOp && !wrOp));
         progWrEn <= !busy && wrOp;
         if (!busy && tableOp) begin
            progAddr        <= tblAddr;
            progConfigSpace <= tablePage_q[PSDA_TBL_CFG_BIT];
         end else if (!busy && hit) begin
            progAddr        <= visAddr;
            progConfigSpace <= 1'b0;
         end
         if (!busy && wrOp) begin
            if (isHigh(opCode)) begin
               progWrData  <= {wrData[7:0], 16'h0000};
               progWrLanes <= (byteMode && byteSel) ? 3'h0 : 3'h4;
            end else if (byteMode) begin
               progWrData  <= {8'h00, wrData[7:0], wrData[7:0]};
               progWrLanes <= byteSel ? 3'h2 : 3'h1;
            end else begin
               progWrData  <= {8'h00, wrData};
               progWrLanes <= 3'h3;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Read answer, one cycle after the fetch
   // ------------------------------------------------------------
   logic pendRd_q;
   logic pendWin_q;
   logic pendHigh_q;
   logic pendByte_q;
   logic pendSel_q;
   logic [15:0] extracted;

   always_ff @(posedge clk) begin
      if (rst) begin
         pendRd_q   <= 1'b0;
         pendWin_q  <= 1'b0;
         pendHigh_q <= 1'b0;
         pendByte_q <= 1'b0;
         pendSel_q  <= 1'b0;
      end else begin
         pendRd_q   <= !busy && (hit || (tableOp && !wrOp));
         pendWin_q  <= hit;
         pendHigh_q <= isHigh(opCode);
         pendByte_q <= byteMode && !hit;
         pendSel_q  <= byteSel;
      end
   end

   // Window reads use word-mode low extraction: upper program byte never seen
   psda_extract u_extract (
      .highWord (pendHigh_q && !pendWin_q),
      .byteMode (pendByte_q),
      .byteSel  (pendSel_q),
      .progWord (progRdData),
      .dataWord (extracted)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         dataValid <= 1'b0;
         dataOut   <= 16'h0000;
         windowHit <= 1'b0;
         cpuStall  <= 1'b0;
      end else begin
         dataValid <= pendRd_q;
         if (pendRd_q)
            dataOut <= extracted;
         windowHit <= hit && !busy;
         cpuStall  <= (hit && !busy && extra != 2'h0) || (stallCnt_q > 2'h1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tablePageReg      <= PSDA_PAGE_RESET;
         visibilityPageReg <= PSDA_PAGE_RESET;
         coreControlReg    <= PSDA_CORE_CTL_RESET;
      end else begin
         tablePageReg      <= tablePage_q;
         visibilityPageReg <= visPage_q;
         coreControlReg    <= coreCtl_q;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Window gating and address formation, judged on the registered outputs
   a_window_gate: assert property (@(posedge clk) disable iff (rst)
      windowHit |-> $past(opValid && coreCtl_q[PSDA_VIS_EN_BIT] && effAddr[PSDA_EA_MSB]))
      else $error("window hit without enable or EA msb");
   a_window_base: assert property (@(posedge clk) disable iff (rst)
      windowHit |-> $past(effAddr) >= PSDA_WINDOW_BASE)
      else $error("window hit below window base");
   a_table_blocks: assert property (@(posedge clk) disable iff (rst)
      (tableOp || $past(tableOp)) |=> !windowHit)
      else $error("window active during table op");
   a_vis_addr: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy) |=> progAddr[15] == $past(visPage_q[0]) && !progAddr[23])
      else $error("window address wrong");
   a_vis_page: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy) |=> progAddr[22:15] == $past(visPage_q) &&
                         progAddr[14:0] == $past(effAddr[14:0]))
      else $error("window page or offset wrong");
   a_win_user: assert property (@(posedge clk) disable iff (rst)
      windowHit |-> progRdEn && !progConfigSpace)
      else $error("window fetch outside user space");

   // Table address and space select
   a_table_addr: assert property (@(posedge clk) disable iff (rst)
      (tableOp && !busy) |=> progAddr == {$past(tablePage_q), $past(effAddr)})
      else $error("table address wrong");
   a_cfg_space: assert property (@(posedge clk) disable iff (rst)
      (tableOp && !busy) |=> progConfigSpace == $past(tablePage_q[PSDA_TBL_CFG_BIT]))
      else $error("space select wrong");
   a_byte_sel: assert property (@(posedge clk) disable iff (rst)
      (tableOp && !busy) |=> pendSel_q == $past(effAddr[0]))
      else $error("byte select not taken from EA bit 0");

   // Read answers, one cycle after the fetch
   a_read_latency: assert property (@(posedge clk) disable iff (rst)
      progRdEn |=> dataValid)
      else $error("read answer missing");
   a_lo_word: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && !pendWin_q && !pendHigh_q && !pendByte_q) |=> dataOut == $past(progRdData[15:0]))
      else $error("low word read wrong");
   a_lo_byte: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && !pendWin_q && !pendHigh_q && pendByte_q) |=>
         dataOut[7:0] == ($past(pendSel_q) ? $past(progRdData[15:8]) : $past(progRdData[7:0])))
      else $error("low byte read wrong");
   a_hi_word: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && !pendWin_q && pendHigh_q && !(pendByte_q && pendSel_q)) |=>
         dataOut[7:0] == $past(progRdData[23:16]))
      else $error("high word read wrong");
   a_hi_phantom: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && pendHigh_q && !pendWin_q) |=> dataOut[15:8] == 8'h00)
      else $error("phantom byte not zero");
   a_hi_sel: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && !pendWin_q && pendHigh_q && pendByte_q && pendSel_q) |=> dataOut == 16'h0000)
      else $error("phantom byte select not zero");
   a_win_low16: assert property (@(posedge clk) disable iff (rst)
      (pendRd_q && pendWin_q) |=> dataOut == $past(progRdData[15:0]))
      else $error("window data wrong");

   // Table writes: a low write must never open the upper lane, or constant data loses its no-op byte
   a_wr_low: assert property (@(posedge clk) disable iff (rst)
      (wrOp && !busy && (opCode == PSDA_OP_TBL_WR_LO) && !byteMode) |=>
         progWrEn && progWrLanes == 3'h3 && progWrData[15:0] == $past(wrData))
      else $error("low word write wrong");
   a_wr_upper: assert property (@(posedge clk) disable iff (rst)
      (wrOp && !busy && (opCode == PSDA_OP_TBL_WR_LO)) |=> !progWrLanes[2])
      else $error("low write reached the upper byte");
   a_wr_high: assert property (@(posedge clk) disable iff (rst)
      (wrOp && !busy && (opCode == PSDA_OP_TBL_WR_HI)) |=> progWrLanes[1:0] == 2'h0)
      else $error("high write reached the low word");

   // Extra cycles for window reads
   a_move_stall: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy && !inRepeat && moveInstr) |=> cpuStall ##1 !cpuStall)
      else $error("move stall length wrong");
   a_other_stall: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy && !inRepeat && !moveInstr) |=> cpuStall ##1 cpuStall ##1 !cpuStall)
      else $error("other stall length wrong");
   a_rep_edge: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy && inRepeat && (repFirst || repLast || repIrqExit || repIrqReentry)) |=>
         cpuStall ##1 cpuStall ##1 !cpuStall)
      else $error("repeat boundary stall wrong");
   a_rep_quiet: assert property (@(posedge clk) disable iff (rst)
      (hit && !busy && inRepeat && !(repFirst || repLast || repIrqExit || repIrqReentry)) |=> !cpuStall)
      else $error("repeat body stalled");
   a_stall_hold: assert property (@(posedge clk) disable iff (rst)
      busy |=> !progRdEn && !progWrEn)
      else $error("op taken during stall countdown");
endmodule

// [dv/psda_prog_mem.sv]
`timescale 1ns/10ps
// Program memory reply model: answers combinationally in the fetch cycle
module psda_prog_mem (
   // Clock
   input  wire logic        clk,
   // Fetch port
   input  wire logic        progRdEn,
   input  wire logic [23:0] progAddr,
   input  wire logic        progConfigSpace,
   output logic      [23:0] progRdData
);
   logic [23:0] junk_q = 24'h0;

   // Outside a fetch the lines move every cycle, so a stale word never looks valid
   always_ff @(posedge clk) begin
      junk_q <= junk_q + 24'h1f3a71;
   end

   // User-space constant data keeps an all-ones upper byte so a stray fetch decodes as a no-op; configuration space gives 3Ch
   assign progRdData = !progRdEn ? junk_q
                     : {progConfigSpace ? 8'h3c : 8'hff, progAddr[15:0] ^ {progAddr[23:16], 8'h5c}};
endmodule

// [dv/program_space_data_access_test.sv]
`timescale 1ns/10ps
module program_space_data_access_test import psda_pkg::*; ;
   logic        clk, rst, tablePageWr, visPageWr, coreCtlWr, opValid, byteMode, moveInstr;
   logic        inRepeat, repFirst, repLast, repIrqExit, repIrqReentry;
   logic        progRdEn, progWrEn, progConfigSpace, dataValid, windowHit, cpuStall, dVal;
   logic [2:0]  progWrLanes;
   logic [7:0]  tablePageReg, visibilityPageReg;
   logic [15:0] regWrData, effAddr, wrData, dataOut, coreControlReg, dOut;
   logic [23:0] progRdData, progAddr, progWrData;
   psda_op_t    opCode;
   int          failures = 0;
   int          n_checks = 0;
   int          stalls;

   psda_bridge dut (.clk(clk), .rst(rst), .tablePageWr(tablePageWr), .visPageWr(visPageWr),
      .coreCtlWr(coreCtlWr), .regWrData(regWrData), .opValid(opValid), .opCode(opCode),
      .effAddr(effAddr), .byteMode(byteMode), .wrData(wrData), .moveInstr(moveInstr),
      .inRepeat(inRepeat), .repFirst(repFirst), .repLast(repLast), .repIrqExit(repIrqExit),
      .repIrqReentry(repIrqReentry), .progRdData(progRdData), .progRdEn(progRdEn),
      .progWrEn(progWrEn), .progAddr(progAddr), .progWrData(progWrData), .progWrLanes(progWrLanes),
      .progConfigSpace(progConfigSpace), .dataValid(dataValid), .dataOut(dataOut),
      .windowHit(windowHit), .cpuStall(cpuStall), .tablePageReg(tablePageReg),
      .visibilityPageReg(visibilityPageReg), .coreControlReg(coreControlReg));

   psda_prog_mem mem (.clk(clk), .progRdEn(progRdEn), .progAddr(progAddr),
      .progConfigSpace(progConfigSpace), .progRdData(progRdData));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [23:0] pw(input logic [23:0] a, input logic c);
      return {c ? 8'h3c : 8'hff, a[15:0] ^ {a[23:16], 8'h5c}};
   endfunction

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wreg(input int sel, input logic [15:0] v);
      @(posedge clk);
      regWrData <= v;
      tablePageWr <= (sel == 0);
      visPageWr <= (sel == 1);
      coreCtlWr <= (sel == 2);
      @(posedge clk);
      {tablePageWr, visPageWr, coreCtlWr} <= 3'h0;
      @(negedge clk);
   endtask

   // Leaves the caller in the fetch cycle, one cycle before the data answer
   task automatic issue(input psda_op_t op, input logic [15:0] ea, input logic bm);
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= op;
      effAddr <= ea;
      byteMode <= bm;
      @(posedge clk);
      opValid <= 1'b0;
      @(negedge clk);
   endtask

   // Collects the data answer and counts stall cycles; long enough for the next op to be taken
   task automatic tail();
      stalls = 0;
      for (int i = 0; i < 6; i++) begin
         stalls += int'(cpuStall);
         @(negedge clk);
         if (i == 0) begin
            dVal = dataValid;
            dOut = dataOut;
         end
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_table_reads();
      logic [7:0]  pg;
      logic [15:0] ea;
      logic [15:0] e;
      logic [23:0] w;
      chk(24'(coreControlReg), 24'(PSDA_CORE_CTL_RESET));
      for (int k = 0; k < 4; k++) begin
         pg = k[1] ? 8'h85 : 8'h12;
         ea = k[0] ? 16'h2345 : 16'hc344;
         wreg(0, {8'h00, pg});
         w = pw({pg, ea}, pg[7]);
         for (int m = 0; m < 4; m++) begin
            issue(m[1] ? PSDA_OP_TBL_RD_HI : PSDA_OP_TBL_RD_LO, ea, m[0]);
            chk(progAddr, {pg, ea});
            chk(24'(progConfigSpace), 24'(pg[7]));
            chk(24'(windowHit), 24'h0);
            tail();
            e = m[1] ? (m[0] && ea[0] ? 16'h0 : {8'h00, w[23:16]})
                     : (m[0] && ea[0] ? {8'h00, w[15:8]} : w[15:0]);
            chk(24'(m[0] ? {8'h00, dOut[7:0]} : dOut), 24'(m[0] ? {8'h00, e[7:0]} : e));
            chk(24'(dVal), 24'h1);
         end
      end
      $display("table reads done");
   endtask

   task automatic t_table_writes();
      wreg(0, 16'h0047);
      @(posedge clk);
      wrData <= 16'hbe5a;
      issue(PSDA_OP_TBL_WR_LO, 16'h1236, 1'b0);
      chk(24'(tablePageReg), 24'h47);
      chk(24'({progWrEn, progWrLanes}), 24'hb);
      chk(progAddr, 24'h471236);
      chk(24'(progWrData[15:0]), 24'hbe5a);
      tail();
      issue(PSDA_OP_TBL_WR_HI, 16'h1236, 1'b0);
      chk(24'({progWrEn, progWrLanes}), 24'hc);
      chk(progAddr, 24'h471236);
      chk(24'(progWrData[23:16]), 24'h5a);
      tail();
      issue(PSDA_OP_TBL_WR_HI, 16'h1237, 1'b1);
      chk(24'(progWrLanes), 24'h0);
      tail();
      issue(PSDA_OP_TBL_WR_LO, 16'h1237, 1'b1);
      chk(24'({progWrEn, progWrLanes}), 24'ha);
      chk(24'(progWrData[15:8]), 24'h5a);
      tail();
      $display("table writes done");
   endtask

   task automatic t_window();
      logic [15:0] ea;
      logic [23:0] a;
      wreg(1, 16'h00a7);
      wreg(2, 16'h0004);
      chk(24'(visibilityPageReg), 24'ha7);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         moveInstr <= (k == 0);
         ea = (k == 2) ? 16'hfffe : 16'h8004;
         issue(PSDA_OP_DATA_RD, ea, k == 1);
         a = {1'b0, 8'ha7, ea[14:0]};
         chk(24'({windowHit, progRdEn, progConfigSpace}), 24'h6);
         chk(progAddr, a);
         tail();
         chk(24'(dOut), pw(a, 1'b0) & 24'h00ffff);
         chk(24'(stalls), (k == 0) ? 24'h1 : 24'h2);
      end
      chk(24'(coreControlReg), 24'h4);
      @(posedge clk);
      moveInstr <= 1'b0;
      $display("window reads done");
   endtask

   task automatic t_refuse();
      issue(PSDA_OP_DATA_RD, 16'h7ffe, 1'b0);
      chk(24'({windowHit, progRdEn}), 24'h0);
      tail();
      wreg(2, 16'h0000);
      issue(PSDA_OP_DATA_RD, 16'h8004, 1'b0);
      chk(24'({windowHit, progRdEn}), 24'h0);
      tail();
      wreg(2, 16'h0004);
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= PSDA_OP_TBL_RD_LO;
      effAddr <= 16'h8010;
      @(posedge clk);
      opCode <= PSDA_OP_DATA_RD;
      @(posedge clk);
      opValid <= 1'b0;
      @(negedge clk);
      chk(24'(windowHit), 24'h0);
      tail();
      chk(24'(stalls), 24'h0);
      issue(PSDA_OP_DATA_RD, 16'h8010, 1'b0);
      chk(24'(windowHit), 24'h1);
      tail();
      $display("refusals done");
   endtask

   task automatic t_repeat();
      @(posedge clk);
      inRepeat <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         {repFirst, repLast, repIrqExit, repIrqReentry} <= (k == 4) ? 4'h0 : (4'h8 >> k);
         issue(PSDA_OP_DATA_RD, 16'h8020, 1'b0);
         tail();
         chk(24'(stalls), (k == 4) ? 24'h0 : 24'h2);
      end
      @(posedge clk);
      inRepeat <= 1'b0;
      {repFirst, repLast, repIrqExit, repIrqReentry} <= 4'h0;
      $display("repeat loop done");
   endtask

   // ----------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      {tablePageWr, visPageWr, coreCtlWr, opValid, byteMode, moveInstr} = 6'h0;
      {inRepeat, repFirst, repLast, repIrqExit, repIrqReentry} = 5'h0;
      {regWrData, effAddr, wrData} = 48'h0;
      opCode = PSDA_OP_NONE;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_table_reads();
      t_table_writes();
      t_window();
      t_refuse();
      t_repeat();
      final_report();
   end

   // Whole run is a few hundred cycles; this allows ample margin
   initial begin
      #400000;
      failures++;
      final_report();
   end
endmodule
